// File: hw/cptc_cfg.svh
// Register map, field positions and reset values of the complementary PWM control slice
`ifndef CPTC_CFG_SVH
`define CPTC_CFG_SVH
// Byte offsets on the Wishbone port
`define CPTC_ADR_CTL0 8'h00
`define CPTC_ADR_CTL1 8'h04
`define CPTC_ADR_DIEN 8'h0C
`define CPTC_ADR_INTF 8'h10
`define CPTC_ADR_SWEV 8'h14
`define CPTC_ADR_CHC0 8'h18
`define CPTC_ADR_CHC2 8'h20
`define CPTC_ADR_CNT 8'h24
`define CPTC_ADR_CAR 8'h2C
`define CPTC_ADR_CV 8'h34
`define CPTC_ADR_CCHP 8'h44
`define CPTC_ADR_DCFG 8'h48
`define CPTC_ADR_DMATB 8'h4C
// Writable bit masks
`define CPTC_WM_CTL0 32'h0000038F
`define CPTC_WM_CTL1 32'h00000300
`define CPTC_WM_DIEN 32'h00000181
`define CPTC_WM_INTF 32'h00000081
`define CPTC_WM_CHC0 32'h00000074
`define CPTC_WM_CHC2 32'h00000005
`define CPTC_WM_CCHP 32'h0000BCFF
`define CPTC_WM_DCFG 32'h00001F1F
// Field positions
`define CPTC_B_CEN 0
`define CPTC_B_UPDATE_DISABLE 1
`define CPTC_B_UPS 2
`define CPTC_B_SPM 3
`define CPTC_B_AUTORELOAD_SHADOW_ENABLE 7
`define CPTC_F_SAMPLE_CLOCK_DIVIDER 9:8
`define CPTC_B_ISO 8
`define CPTC_B_ISON 9
`define CPTC_B_UPIE 0
`define CPTC_B_BREAK_INTERRUPT_ENABLE 7
`define CPTC_B_UPDEN 8
`define CPTC_B_UPIF 0
`define CPTC_B_BREAK_INTERRUPT_FLAG 7
`define CPTC_B_UPG 0
`define CPTC_B_COMFEN 2
`define CPTC_F_COMCTL 6:4
`define CPTC_B_CHEN 0
`define CPTC_B_CHNEN 2
`define CPTC_F_DT 7:0
`define CPTC_B_IOS 10
`define CPTC_B_ROS 11
`define CPTC_B_BREAK_ENABLE 12
`define CPTC_B_BREAK_POLARITY 13
`define CPTC_B_PRIMARY_OUTPUT_ENABLE 15
`define CPTC_F_DMA_START_ADDRESS_FIELD 4:0
`define CPTC_F_DMA_TRANSFER_COUNT_FIELD 12:8
// Reset values
`define CPTC_RST_REG 32'h00000000
`define CPTC_RST_CAR 32'h0000FFFF
`endif

// File: hw/cptc_pkg.sv
// Types shared by the complementary PWM control slice
package cptc_pkg;
   // Compare output modes of the prepared signal
   typedef enum logic [2:0] {
      CPTC_CMP_HOLD = 3'h0,
      CPTC_CMP_SET = 3'h1,
      CPTC_CMP_CLR = 3'h2,
      CPTC_CMP_TOG = 3'h3,
      CPTC_CMP_LOW = 3'h4,
      CPTC_CMP_HIGH = 3'h5,
      CPTC_CMP_PWMA = 3'h6,
      CPTC_CMP_PWMB = 3'h7
   } cptc_cmp_type;
   // DMA burst sequencer states
   typedef enum logic [1:0] {
      CPTC_DMA_IDLE = 2'h1,
      CPTC_DMA_BURST = 2'h2
   } cptc_dma_type;
endpackage : cptc_pkg

// File: hw/cptc_top.sv
// Complementary PWM control slice: dead time, break, single pulse, DMA burst, Wishbone registers
// Operation
// - Dead time only when main, complementary and primary output enables are all one.
// - Prepared rise clears complementary at once, main waits one dead time.
// - Prepared fall clears main at once, complementary waits one dead time.
// - Dead time not shorter than a pulse keeps that output inactive.
// - Break from pin or crystal stuck event, only with break enable set.
// - Break pin active level follows the break polarity bit.
// - Break clears primary output enable; outputs then go to idle levels.
// - After break, output enables drop when idle off-state select is zero.
// - Break forces outputs low first, idle levels after one dead time.
// - Each break sets the break flag; interrupt raised when enabled.
// - Single pulse: update event clears counter and counter enable.
// - Single pulse: enable holds until update or software clear; clear holds count.
// - Single pulse: trigger edge sets counter enable and starts counting.
// - Fast compare: in single pulse mode, trigger edge forces post-match prepared state in PWM modes.
// - DMA event requests transfers; buffer accesses redirect to start-address register.
// - Transfer count plus one requests, each to the next word register.
// - Each further DMA event repeats the whole burst; events arriving during a burst are dropped.
// - Counter stops while core is halted and the hold bit is one.
// - Sample clock divides by one, two or four; code three reserved.
// - Auto-reload goes through a shadow when shadow enable is one.
// - Update source bit zero: all causes request; one: only overflow.
// - Update disable blocks events and shadow loads; software trigger still reinitialises.
// - With primary output enable clear, outputs show their idle-state bits.
//
// The implementer's own choice: the Wishbone register port.
`include "cptc_cfg.svh"

module cptc_top import cptc_pkg::*; #(
   parameter int CNT_W = 16,
   parameter int DT_W = 8
) (
   // Clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   // Wishbone slave
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [7:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   // Trigger, break and debug inputs
   input wire logic TRIG_I,
   input wire logic BRK_I,
   input wire logic XTAL_STUCK_I,
   input wire logic DBG_HALT_I,
   input wire logic DBG_HOLD_I,
   // Power stage outputs
   output logic MAIN_O,
   output logic MAIN_OE_O,
   output logic COMP_O,
   output logic COMP_OE_O,
   // Requests
   output logic BRK_IRQ_O,
   output logic UPD_IRQ_O,
   output logic DMA_REQ_O
);

   // Refuse widths the register layout cannot hold
   if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt
      $error("CNT_W must lie between 2 and 32");
   end
   if (DT_W < 1 || DT_W > 8) begin : g_bad_dt
      $error("DT_W must lie between 1 and 8");
   end

   logic ack_q;
   logic [31:0] dat_q;
   logic req;
   logic acc_en;
   logic wr_en;
   logic tb_hit;
   logic [7:0] eff_adr;
   logic [31:0] rd_val;
   logic [31:0] wdat;
   logic [31:0] ctl0_q, ctl1_q, dien_q, intf_q, chc0_q, chc2_q, cchp_q, dcfg_q;
   logic [CNT_W-1:0] cnt_q, car_q, car_sh_q, cv_q, car_act;
   logic [1:0] div_q;
   logic tick;
   logic trig_q, trig_rise;
   logic brk_act, brk_p_q, primary_output_enable_eff;
   logic cnt_run, ovf, upd_sw, upd_evt, upd_req;
   logic single_pulse_select, prep_q, prep_p_q, prep_edge, fast_q, fast_hit, pwm, post, match;
   logic [DT_W-1:0] dead_time_setting, dt_cnt_q, off_cnt_q;
   logic dt_on, dt_done, idle_done;
   cptc_dma_type dma_st_q;
   logic [4:0] left_q, idx_q;
   cptc_cmp_type mode;

   // Byte-lane merge of write data over the current register image
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      return (old & ~m) | (nw & m);
   endfunction : merge

   // Sample clock enable from the divide field; reserved code acts as divide by four
   function automatic logic dts_tick(input logic [1:0] sample_clock_divider, input logic [1:0] div);
      logic t;
      t = 1'b0;
      if (sample_clock_divider == 2'h0) begin
         t = 1'b1;
      end else if (sample_clock_divider == 2'h1) begin
         t = div[0];
      end else begin
         t = (div == 2'h3);
      end
      return t;
   endfunction : dts_tick

   // Bus strobes: one wait state, the write lands on the acknowledging edge
   assign req = CYC_I & STB_I;
   assign acc_en = req & ack_q;
   assign wr_en = acc_en & WE_I;
   assign ACK_O = acc_en;
   assign DAT_O = dat_q;

   assign tb_hit = (ADR_I == `CPTC_ADR_DMATB);
   assign eff_adr = tb_hit ? {6'(dcfg_q[`CPTC_F_DMA_START_ADDRESS_FIELD]) + 6'(idx_q), 2'h0} : ADR_I;
   assign wdat = merge(rd_val, DAT_I, SEL_I);

   // Acknowledge and read data capture
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         ack_q <= 1'b0;
         dat_q <= `CPTC_RST_REG;
      end else begin
         ack_q <= req & ~ack_q;
         if (req && !ack_q && !WE_I) begin
            dat_q <= rd_val;
         end
      end
   end

   // Read decode; unmapped offsets read zero, buffer reads return the redirected register
   always_comb begin
      rd_val = `CPTC_RST_REG;
      if (eff_adr == `CPTC_ADR_CTL0) begin
         rd_val = ctl0_q & `CPTC_WM_CTL0;
      end else if (eff_adr == `CPTC_ADR_CTL1) begin
         rd_val = ctl1_q & `CPTC_WM_CTL1;
      end else if (eff_adr == `CPTC_ADR_DIEN) begin
         rd_val = dien_q & `CPTC_WM_DIEN;
      end else if (eff_adr == `CPTC_ADR_INTF) begin
         rd_val = intf_q & `CPTC_WM_INTF;
      end else if (eff_adr == `CPTC_ADR_CHC0) begin
         rd_val = chc0_q & `CPTC_WM_CHC0;
      end else if (eff_adr == `CPTC_ADR_CHC2) begin
         rd_val = chc2_q & `CPTC_WM_CHC2;
      end else if (eff_adr == `CPTC_ADR_CNT) begin
         rd_val = 32'(cnt_q);
      end else if (eff_adr == `CPTC_ADR_CAR) begin
         rd_val = 32'(car_q);
      end else if (eff_adr == `CPTC_ADR_CV) begin
         rd_val = 32'(cv_q);
      end else if (eff_adr == `CPTC_ADR_CCHP) begin
         rd_val = (cchp_q & `CPTC_WM_CCHP) & ~(32'h1 << `CPTC_B_PRIMARY_OUTPUT_ENABLE);
         rd_val[`CPTC_B_PRIMARY_OUTPUT_ENABLE] = primary_output_enable_eff;
      end else if (eff_adr == `CPTC_ADR_DCFG) begin
         rd_val = dcfg_q & `CPTC_WM_DCFG;
      end
   end

   // Plain configuration registers
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         ctl1_q <= `CPTC_RST_REG;
         dien_q <= `CPTC_RST_REG;
         chc0_q <= `CPTC_RST_REG;
         chc2_q <= `CPTC_RST_REG;
         dcfg_q <= `CPTC_RST_REG;
         cv_q <= '0;
         car_q <= CNT_W'(`CPTC_RST_CAR);
      end else if (wr_en) begin
         if (eff_adr == `CPTC_ADR_CTL1) ctl1_q <= wdat & `CPTC_WM_CTL1;
         if (eff_adr == `CPTC_ADR_DIEN) dien_q <= wdat & `CPTC_WM_DIEN;
         if (eff_adr == `CPTC_ADR_CHC0) chc0_q <= wdat & `CPTC_WM_CHC0;
         if (eff_adr == `CPTC_ADR_CHC2) chc2_q <= wdat & `CPTC_WM_CHC2;
         if (eff_adr == `CPTC_ADR_DCFG) dcfg_q <= wdat & `CPTC_WM_DCFG;
         if (eff_adr == `CPTC_ADR_CV) cv_q <= wdat[CNT_W-1:0];
         if (eff_adr == `CPTC_ADR_CAR) car_q <= wdat[CNT_W-1:0];
      end
   end

   // Control register 0; hardware edits to the enable bit win over the write
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         ctl0_q <= `CPTC_RST_REG;
      end else begin
         if (wr_en && eff_adr == `CPTC_ADR_CTL0) ctl0_q <= wdat & `CPTC_WM_CTL0;
         if (single_pulse_select && upd_evt) ctl0_q[`CPTC_B_CEN] <= 1'b0;
         if (single_pulse_select && trig_rise) ctl0_q[`CPTC_B_CEN] <= 1'b1;
      end
   end
   assign single_pulse_select = ctl0_q[`CPTC_B_SPM];

   // Protection register; primary enable cannot be set while a break stands
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         cchp_q <= `CPTC_RST_REG;
      end else begin
         if (wr_en && eff_adr == `CPTC_ADR_CCHP) cchp_q <= wdat & `CPTC_WM_CCHP;
         if (brk_act) cchp_q[`CPTC_B_PRIMARY_OUTPUT_ENABLE] <= 1'b0;
      end
   end
   assign dead_time_setting = cchp_q[DT_W-1:0];

   assign brk_act = cchp_q[`CPTC_B_BREAK_ENABLE] &
                    ((cchp_q[`CPTC_B_BREAK_POLARITY] ? BRK_I : ~BRK_I) | XTAL_STUCK_I);
   // Enable seen by the output stage falls in the break cycle itself, not an edge later
   assign primary_output_enable_eff = cchp_q[`CPTC_B_PRIMARY_OUTPUT_ENABLE] & ~brk_act;

   // Flags: write zero clears, a same-cycle event wins
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         intf_q <= `CPTC_RST_REG;
         brk_p_q <= 1'b0;
      end else begin
         brk_p_q <= brk_act;
         if (wr_en && eff_adr == `CPTC_ADR_INTF) begin
            intf_q <= intf_q & (wdat | ~`CPTC_WM_INTF) & `CPTC_WM_INTF;
         end
         if (brk_act && !brk_p_q) intf_q[`CPTC_B_BREAK_INTERRUPT_FLAG] <= 1'b1;
         if (upd_req) intf_q[`CPTC_B_UPIF] <= 1'b1;
      end
   end
   assign BRK_IRQ_O = intf_q[`CPTC_B_BREAK_INTERRUPT_FLAG] & dien_q[`CPTC_B_BREAK_INTERRUPT_ENABLE];
   assign UPD_IRQ_O = intf_q[`CPTC_B_UPIF] & dien_q[`CPTC_B_UPIE];

   // Update event sources
   assign upd_sw = wr_en && (eff_adr == `CPTC_ADR_SWEV) && wdat[`CPTC_B_UPG];
   assign cnt_run = ctl0_q[`CPTC_B_CEN] & ~(DBG_HALT_I & DBG_HOLD_I);
   assign ovf = cnt_run && (cnt_q >= car_act);
   assign upd_evt = (upd_sw | ovf) & ~ctl0_q[`CPTC_B_UPDATE_DISABLE];
   assign upd_req = upd_evt & (ovf | ~ctl0_q[`CPTC_B_UPS]);
   assign car_act = ctl0_q[`CPTC_B_AUTORELOAD_SHADOW_ENABLE] ? car_sh_q : car_q;

   // Counter; software trigger reinitialises even with updates disabled
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         cnt_q <= '0;
      end else if (upd_sw || ovf) begin
         cnt_q <= '0;
      end else if (wr_en && eff_adr == `CPTC_ADR_CNT) begin
         cnt_q <= wdat[CNT_W-1:0];
      end else if (cnt_run) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // Auto-reload shadow loads only on real update events
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         car_sh_q <= CNT_W'(`CPTC_RST_CAR);
      end else if (upd_evt) begin
         car_sh_q <= car_q;
      end
   end

   // Trigger edge detect and sample clock divider
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         trig_q <= 1'b0;
         div_q <= 2'h0;
      end else begin
         trig_q <= TRIG_I;
         div_q <= div_q + 2'h1;
      end
   end
   assign trig_rise = TRIG_I & ~trig_q;
   assign tick = dts_tick(ctl0_q[`CPTC_F_SAMPLE_CLOCK_DIVIDER], div_q);

   // Prepared output signal
   assign mode = cptc_cmp_type'(chc0_q[`CPTC_F_COMCTL]);
   assign pwm = (mode == CPTC_CMP_PWMA) || (mode == CPTC_CMP_PWMB);
   assign post = (mode == CPTC_CMP_PWMB);
   assign match = (cnt_q == cv_q);
   // fast compare in PWM modes only
   assign fast_hit = chc0_q[`CPTC_B_COMFEN] & single_pulse_select & pwm & trig_rise;

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         fast_q <= 1'b0;
      end else if (fast_hit) begin
         fast_q <= 1'b1;
      end else if (match || !ctl0_q[`CPTC_B_CEN]) begin
         fast_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         prep_q <= 1'b0;
      end else if (fast_hit || fast_q) begin
         prep_q <= post;
      end else begin
         case (mode)
            CPTC_CMP_SET: if (match) prep_q <= 1'b1;
            CPTC_CMP_CLR: if (match) prep_q <= 1'b0;
            CPTC_CMP_TOG: if (match) prep_q <= ~prep_q;
            CPTC_CMP_LOW: prep_q <= 1'b0;
            CPTC_CMP_HIGH: prep_q <= 1'b1;
            CPTC_CMP_PWMA: prep_q <= (cnt_q < cv_q);
            CPTC_CMP_PWMB: prep_q <= (cnt_q >= cv_q);
            default: prep_q <= prep_q;
         endcase
      end
   end

   // dead-time counters run on sample ticks
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         prep_p_q <= 1'b0;
         dt_cnt_q <= '0;
         off_cnt_q <= '0;
      end else begin
         prep_p_q <= prep_q;
         // The edge cycle's own tick counts, so a setting of N delays by exactly N ticks
         if (prep_edge) begin
            dt_cnt_q <= DT_W'(tick);
         end else if (tick && dt_cnt_q < dead_time_setting) begin
            dt_cnt_q <= dt_cnt_q + 1'b1;
         end
         if (primary_output_enable_eff) begin
            off_cnt_q <= '0;
         end else if (tick && off_cnt_q < dead_time_setting) begin
            off_cnt_q <= off_cnt_q + 1'b1;
         end
      end
   end
   assign prep_edge = prep_q ^ prep_p_q;
   // Stale count must not open the output in the edge cycle
   assign dt_done = prep_edge ? (dead_time_setting == '0) : (dt_cnt_q >= dead_time_setting);
   assign idle_done = (off_cnt_q >= dead_time_setting);
   assign dt_on = chc2_q[`CPTC_B_CHEN] & chc2_q[`CPTC_B_CHNEN] & primary_output_enable_eff;

   // Output stage
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         MAIN_O <= 1'b0;
         COMP_O <= 1'b0;
         MAIN_OE_O <= 1'b0;
         COMP_OE_O <= 1'b0;
      end else if (!primary_output_enable_eff) begin
         // low first, idle after a dead time
         MAIN_O <= idle_done & ctl1_q[`CPTC_B_ISO];
         COMP_O <= idle_done & ctl1_q[`CPTC_B_ISON];
         MAIN_OE_O <= cchp_q[`CPTC_B_IOS];
         COMP_OE_O <= cchp_q[`CPTC_B_IOS];
      end else begin
         // long dead time swallows the pulse
         MAIN_O <= chc2_q[`CPTC_B_CHEN] & prep_q & (~dt_on | dt_done);
         COMP_O <= chc2_q[`CPTC_B_CHNEN] & ~prep_q & (~dt_on | dt_done);
         MAIN_OE_O <= chc2_q[`CPTC_B_CHEN] | cchp_q[`CPTC_B_ROS];
         COMP_OE_O <= chc2_q[`CPTC_B_CHNEN] | cchp_q[`CPTC_B_ROS];
      end
   end

   // DMA burst sequencer; events during a burst are dropped
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         dma_st_q <= CPTC_DMA_IDLE;
         left_q <= 5'h00;
         idx_q <= 5'h00;
      end else begin
         case (dma_st_q)
            CPTC_DMA_IDLE: begin
               if (upd_req && dien_q[`CPTC_B_UPDEN]) begin
                  dma_st_q <= CPTC_DMA_BURST;
                  left_q <= dcfg_q[`CPTC_F_DMA_TRANSFER_COUNT_FIELD];
                  idx_q <= 5'h00;
               end
            end
            CPTC_DMA_BURST: begin
               if (acc_en && tb_hit) begin
                  if (left_q == 5'h00) begin
                     dma_st_q <= CPTC_DMA_IDLE;
                     idx_q <= 5'h00;
                  end else begin
                     left_q <= left_q - 5'h01;
                     idx_q <= idx_q + 5'h01;
                  end
               end
            end
            default: dma_st_q <= CPTC_DMA_IDLE;
         endcase
      end
   end
   // request held for the pending transfer
   assign DMA_REQ_O = (dma_st_q == CPTC_DMA_BURST);

   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);

   sequence s_prep_rise;
      $rose(prep_q) ##0 dt_on;
   endsequence
   sequence s_prep_fall;
      $fell(prep_q) ##0 dt_on;
   endsequence
   sequence s_break_off;
      $fell(primary_output_enable_eff) ##0 (dead_time_setting != '0);
   endsequence

   a_comp_clear_rise: assert property (s_prep_rise |=> !COMP_O)
      else $error("complementary output not cleared on prepared rise");
   a_main_clear_fall: assert property (s_prep_fall |=> !MAIN_O)
      else $error("main output not cleared on prepared fall");
   a_outputs_exclusive: assert property ($past(dt_on) |-> !(MAIN_O && COMP_O))
      else $error("both outputs active with dead time on");
   a_break_flag_set: assert property ($rose(brk_act) |=> intf_q[`CPTC_B_BREAK_INTERRUPT_FLAG])
      else $error("break flag not set");
   a_break_enable_drop: assert property (brk_act |=> !cchp_q[`CPTC_B_PRIMARY_OUTPUT_ENABLE])
      else $error("primary enable survived a break");
   a_break_low_first: assert property (s_break_off |=> !MAIN_O && !COMP_O)
      else $error("outputs not reset before idle levels");
   a_idle_enable: assert property (!primary_output_enable_eff |=> MAIN_OE_O == $past(cchp_q[`CPTC_B_IOS]))
      else $error("output enable does not follow idle off-state select");
   a_spm_stop: assert property (single_pulse_select && upd_evt && !trig_rise && !wr_en
                                |=> !ctl0_q[`CPTC_B_CEN] && cnt_q == '0)
      else $error("single pulse did not stop");
   a_trig_start: assert property (single_pulse_select && trig_rise |=> ctl0_q[`CPTC_B_CEN])
      else $error("trigger did not start counter");
   a_debug_hold: assert property (DBG_HALT_I && DBG_HOLD_I && !upd_sw && !wr_en
                                  |=> $stable(cnt_q))
      else $error("counter moved while held in debug");
   a_dma_load: assert property ($rose(DMA_REQ_O) |-> left_q == $past(dcfg_q[`CPTC_F_DMA_TRANSFER_COUNT_FIELD]))
      else $error("burst length not loaded from transfer count");
   a_upd_source: assert property (ctl0_q[`CPTC_B_UPS] && !ovf |-> !upd_req)
      else $error("update request from a non-overflow source");
   a_wb_ack_once: assert property (ACK_O |=> !ACK_O)
      else $error("acknowledge held for two cycles");

endmodule : cptc_top

// File: tb/cptc_switch_model.sv
// Power switch stage model: counts cycles with both switches conducting
module cptc_switch_model (
   // Clock
   input wire logic clk_i,
   // Gate drives from the slice
   input wire logic main_i,
   input wire logic main_oe_i,
   input wire logic comp_i,
   input wire logic comp_oe_i,
   // Shoot-through cycles seen
   output int shorts_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial shorts_o = 0;
   // Both legs on at once would short the supply, so any such cycle is counted
   always @(negedge clk_i) begin
      if ((main_i & main_oe_i & comp_i & comp_oe_i) === 1'h1) shorts_o <= shorts_o + 1;
   end
endmodule : cptc_switch_model

// File: tb/cptc_tb_top.sv
// Self-checking bench of the complementary PWM control slice
module cptc_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, trig = 0, brk = 0, xtal = 0, halt = 0;
   logic hold = 0, ack, m, moe, c, coe, birq, uirq, dreq;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hF;
   logic [31:0] dat = 32'h00000000, dat_o, rd, rv, hm, hc;
   int n_errors = 0, n_checks = 0, seed = 10703, shorts;
   int dead_time_sample_clock[2] = '{2, 6};
   logic [31:0] dq[$];
   always #10 clk = ~clk;
   cptc_top DUT (.CLK_SYS_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
      .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .TRIG_I(trig), .BRK_I(brk),
      .XTAL_STUCK_I(xtal), .DBG_HALT_I(halt), .DBG_HOLD_I(hold), .MAIN_O(m), .MAIN_OE_O(moe),
      .COMP_O(c), .COMP_OE_O(coe), .BRK_IRQ_O(birq), .UPD_IRQ_O(uirq), .DMA_REQ_O(dreq));
   cptc_switch_model PSW (.clk_i(clk), .main_i(m), .main_oe_i(moe), .comp_i(c),
      .comp_oe_i(coe), .shorts_o(shorts));
   // Verdict and end of run
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // Classic Wishbone cycle; ack is sampled on the rising edge where the write lands, read data was captured one edge earlier
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'h1 && k < 50);
      if (k >= 50) begin
         n_errors++;
         summarize();
      end
      rd = dat_o;
      cyc <= 1'h0;
      stb <= 1'h0;
   endtask : wb
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      wb(0, 8'h00, 0);
      chk("ctl0_reset", 32'h00000000, rd);
      wb(0, 8'h2C, 0);
      chk("car_reset", 32'h0000FFFF, rd);
      wb(0, 8'h3C, 0);
      chk("unmapped", 32'h00000000, rd);
      // Random control word, counter enable kept off so single pulse cannot clear it
      rv = $random(seed) & 32'hFFFFFFFE;
      wb(1, 8'h00, rv);
      wb(0, 8'h00, 0);
      chk("ctl0_rw", rv & 32'h0000038E, rd);
      wb(1, 8'h00, 0);
      // Period of ten clocks, prepared signal high for five
      wb(1, 8'h2C, 32'h00000009);
      wb(1, 8'h34, 32'h00000005);
      wb(1, 8'h18, 32'h00000060);
      wb(1, 8'h20, 32'h00000005);
      wb(1, 8'h00, 32'h00000001);
      // High time of each leg shrinks by the dead time
      foreach (dead_time_sample_clock[i]) begin
         wb(1, 8'h44, 32'h00008000 | dead_time_sample_clock[i]);
         repeat (30) @(negedge clk);
         hm = 0;
         hc = 0;
         repeat (100) begin
            @(negedge clk);
            hm += m;
            hc += c;
         end
         chk("main_high", (dead_time_sample_clock[i] < 5) ? 10 * (5 - dead_time_sample_clock[i]) : 0, hm);
         chk("comp_high", (dead_time_sample_clock[i] < 5) ? 10 * (5 - dead_time_sample_clock[i]) : 0, hc);
      end
      // Break from the pin, active high, idle levels main 1 comp 0
      wb(1, 8'h04, 32'h00000100);
      wb(1, 8'h0C, 32'h00000080);
      wb(1, 8'h44, 32'h0000B402);
      brk <= 1'h1;
      repeat (3) @(posedge clk);
      brk <= 1'h0;
      repeat (10) @(negedge clk);
      chk("main_idle", 1, m);
      chk("comp_idle", 0, c);
      chk("main_oe", 1, moe);
      chk("comp_oe", 1, coe);
      chk("brk_irq", 1, birq);
      wb(0, 8'h10, 0);
      chk("brk_flag", 1, rd[7]);
      wb(0, 8'h44, 0);
      chk("primary_output_enable", 0, rd[15]);
      // Crystal event only counts with break enabled; pin held idle-high
      brk <= 1'h1;
      for (int e = 0; e < 2; e++) begin
         wb(1, 8'h10, 0);
         wb(1, 8'h44, 32'h00008402 | (e << 12));
         xtal <= 1'h1;
         repeat (3) @(posedge clk);
         xtal <= 1'h0;
         wb(0, 8'h10, 0);
         chk("xtal_flag", e, rd[7]);
      end
      // Single pulse stops and clears at the update
      wb(1, 8'h00, 32'h00000009);
      repeat (40) @(negedge clk);
      wb(0, 8'h00, 0);
      chk("spm_ctl0", 32'h00000008, rd);
      wb(0, 8'h24, 0);
      chk("spm_cnt", 0, rd);
      // Counter frozen while the core is halted with hold set
      halt <= 1'h1;
      hold <= 1'h1;
      wb(1, 8'h24, 32'h00000005);
      wb(1, 8'h00, 32'h00000001);
      repeat (20) @(negedge clk);
      wb(0, 8'h24, 0);
      chk("halt_cnt", 5, rd);
      halt <= 1'h0;
      wb(1, 8'h00, 0);
      // Two-word burst from the unmapped word below the compare value
      wb(1, 8'h0C, 32'h00000101);
      wb(1, 8'h48, 32'h0000010C);
      for (int b = 0; b < 2; b++) begin
         wb(1, 8'h14, 32'h00000001);
         repeat (2) @(negedge clk);
         chk("dma_req", 1, dreq);
         chk("upd_irq", 1, uirq);
         repeat (2) begin
            rv = $random(seed);
            dq.push_back(rv & 32'h0000FFFF);
            wb(1, 8'h4C, rv);
         end
         repeat (2) @(negedge clk);
         chk("dma_done", 0, dreq);
         wb(0, 8'h34, 0);
         chk("dma_cv", dq[1], rd);
         dq.delete();
      end
      // Trigger edge starts the counter in single pulse mode
      wb(1, 8'h00, 32'h00000008);
      trig <= 1'h1;
      wb(0, 8'h00, 0);
      chk("trig_cen", 32'h00000009, rd);
      trig <= 1'h0;
      // Software update neither flags nor requests DMA with disable or source set
      for (int u = 1; u < 3; u++) begin
         wb(1, 8'h00, 32'(u) << 1);
         wb(1, 8'h10, 0);
         wb(1, 8'h14, 32'h00000001);
         wb(0, 8'h10, 0);
         chk("upd_gate", 0, rd[0]);
         chk("upd_dma", 0, dreq);
      end
      chk("shoot_through", 0, 32'(shorts));
      summarize();
   end
endmodule : cptc_tb_top
